// ---- design/tecos_regs.vh ----
// constants for the event counter / one-shot timer channel
`ifndef TECOS_REGS_VH
`define TECOS_REGS_VH
`define TECOS_CNT_W 16
`define TECOS_CNT_MAX 16'hFFFF
`define TECOS_CNT_ZERO 16'h0000
`define TECOS_CNT_RST 16'hFFFF
`define TECOS_MODE_EVENT 1'h0
`define TECOS_MODE_ONESHOT 1'h1
`define TECOS_SRC_PIN 2'h0
`define TECOS_SRC_NB 2'h1
`define TECOS_SRC_NA 2'h2
`define TECOS_SRC_QUAD 2'h3
`define TECOS_CLK_F1 2'h0
`define TECOS_CLK_F8 2'h1
`define TECOS_CLK_F32 2'h2
`define TECOS_CLK_SUB 2'h3
`define TECOS_PRE_W 5
`define TECOS_OUT_PORT 2'h0
`define TECOS_OUT_PULSE 2'h1
`define TECOS_OUT_DIR 2'h2
`define TECOS_ST_IDLE 1'h0
`define TECOS_ST_RUN 1'h1
`define TECOS_READ_JUNK 16'h0000
`endif

// ---- design/tecos_sync.v ----
// two flip-flop synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module tecos_sync
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // async input
  input wire din,
  // synchronised outputs
  output wire dout,
  output wire rise,
  output wire fall
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign dout = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule // tecos_sync

// ---- design/tecos_presc.v ----
// prescaler giving one-cycle ticks at f1, f8, f32 and the sub-clock source
`timescale 1ns/100ps
`include "tecos_regs.vh"
module tecos_presc
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // source select and synchronised sub-clock rising-edge pulse
  input wire [1:0] clk_sel,
  input wire sub_rise,
  // tick output
  output reg tick
);
  reg [`TECOS_PRE_W-1:0] div_reg;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_reg <= 5'h00;
    else
      div_reg <= div_reg + 5'h01;
  end
  always @*
  begin
    case (clk_sel)
      `TECOS_CLK_F1: tick = 1'h1;
      `TECOS_CLK_F8: tick = (div_reg[2:0] == 3'h7);
      `TECOS_CLK_F32: tick = (div_reg == 5'h1F);
      `TECOS_CLK_SUB: tick = sub_rise;
      default: tick = 1'h0;
    endcase
  end
endmodule // tecos_presc

// ---- design/tecos_timer.v ----
// 16-bit event counter / one-shot timer channel
`timescale 1ns/100ps
`include "tecos_regs.vh"
// Notes on behaviour
// [R01] event mode counts chosen pin edge or a neighbour timer overflow
// [R02] single-phase direction set by software or by the direction pin
// [R03] without free-run, reload value on overflow or underflow, keep counting
// [R04] divide by FFFF-n+1 counting up, n+1 counting down
// [R05] event counting runs while start flag is one, halts when zero
// [R06] event mode raises interrupt on each overflow and underflow
// [R07] event mode read returns live count
// [R08] write when stopped loads reload and counter; running loads reload only
// [R09] free-run: no reload on overflow or underflow, counter wraps
// [R10] pulse output inverts output pin at each overflow or underflow
// [R11] output pin is general port, pulse output, or direction input
// [R12] two-phase channel counts pulse pair on input and output pins
// [R13] two-phase direction comes from phase relation, not software
// [R14] phase b high: count up on a rising, down on a falling
// [R15] software makes both phase pins inputs during two-phase counting
// [R16] one-shot source is f1, f8, f32 or the sub-clock source
// [R17] one-shot counts down from n, active for n source cycles
// [R18] one-shot at zero reloads then stops; clearing start flag stops too
// [R19] trigger during one-shot run reloads and restarts
// [R20] one-shot starts on trigger pin, timer overflow, or software flag
// [R21] one-shot raises interrupt when count reaches zero
// [R22] one-shot read returns an indeterminate value
// [R23] one-shot input pin is port or trigger; output pin port or pulse
// [R24] one-shot pulse output active during down-count, inactive at end
module tecos_timer
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // mode configuration
  input wire mode_sel,
  input wire [1:0] src_sel,
  input wire edge_fall,
  input wire dir_from_pin,
  input wire dir_down,
  input wire free_run,
  input wire [1:0] out_func,
  input wire trig_pin_en,
  input wire trig_nb_en,
  input wire [1:0] clk_sel,
  // control flags
  input wire count_start,
  input wire oneshot_start,
  // timer register access
  input wire wr_en,
  input wire [15:0] wr_data,
  // neighbour overflow pulses and pins
  input wire neighbour_b_timer,
  input wire neighbour_a_timer,
  input wire timer_in_pin,
  input wire timer_out_pin_in,
  input wire subclock_div32_source,
  // port latch for general port use of output pin
  input wire port_level,
  // outputs
  output reg [15:0] rd_data,
  output reg timer_out_pin,
  output reg timer_out_pin_oe_n,
  output reg irq,
  output reg running
);
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [15:0] reload_reg;
  reg [15:0] reload_next;
  reg st_reg;
  reg st_next;
  reg pout_reg;
  reg pout_next;
  reg irq_next;
  reg os_start_d_reg;
  reg [15:0] rd_next;
  reg drv_next;
  wire in_lvl;
  wire in_rise;
  wire in_fall;
  wire ph_b_lvl;
  wire sub_rise;
  wire tick;
  reg ev;
  reg down;
  reg trig;
  reg wrap;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  tecos_sync u_sync_in
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(timer_in_pin),
    .dout(in_lvl),
    .rise(in_rise),
    .fall(in_fall)
  );
  tecos_sync u_sync_ph_b
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(timer_out_pin_in),
    .dout(ph_b_lvl),
    .rise(),
    .fall()
  );
  tecos_sync u_sync_sub
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(subclock_div32_source),
    .dout(),
    .rise(sub_rise),
    .fall()
  );
  // [R16] one-shot source select
  tecos_presc u_presc
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_sel(clk_sel),
    .sub_rise(sub_rise),
    .tick(tick)
  );
  // ----------------------------------------
  // event source and direction
  // ----------------------------------------
  always @*
  begin
    ev = 1'h0;
    down = dir_down;
    case (src_sel)
      // [R01] pin edge select
      `TECOS_SRC_PIN: ev = edge_fall ? in_fall : in_rise;
      // [R01] neighbour overflow source
      `TECOS_SRC_NB: ev = neighbour_b_timer;
      `TECOS_SRC_NA: ev = neighbour_a_timer;
      // [R12] two-phase count source
      `TECOS_SRC_QUAD: ev = ph_b_lvl & (in_rise | in_fall);
      default: ev = 1'h0;
    endcase
    // [R02] direction by pin or software
    if (src_sel != `TECOS_SRC_QUAD && dir_from_pin && out_func == `TECOS_OUT_DIR)
      down = ph_b_lvl;
    // [R13] [R14] phase-derived direction
    if (src_sel == `TECOS_SRC_QUAD)
      down = in_fall;
  end
  // ----------------------------------------
  // counter, reload and output
  // ----------------------------------------
  always @*
  begin
    cnt_next = cnt_reg;
    reload_next = reload_reg;
    st_next = st_reg;
    pout_next = pout_reg;
    irq_next = 1'h0;
    // [R20] one-shot triggers
    trig = (oneshot_start & ~os_start_d_reg) | (trig_pin_en & in_rise)
      | (trig_nb_en & neighbour_b_timer);
    wrap = 1'h0;
    // [R08] write to reload, and counter when stopped
    if (wr_en)
    begin
      reload_next = wr_data;
      if (!running)
        cnt_next = wr_data;
    end
    if (mode_sel == `TECOS_MODE_EVENT)
    begin
      st_next = count_start;
      // [R05] count only while start flag set
      if (count_start && ev)
      begin
        // [R04] up wraps after FFFF, down after 0000
        wrap = down ? (cnt_reg == `TECOS_CNT_ZERO) : (cnt_reg == `TECOS_CNT_MAX);
        cnt_next = down ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
        if (wrap)
        begin
          // [R03] [R09] reload unless free-run
          if (!free_run)
            cnt_next = reload_next;
          // [R06] interrupt on wrap
          irq_next = 1'h1;
          // [R10] toggle pulse output
          pout_next = ~pout_reg;
        end
      end
    end
    else
    begin
      case (st_reg)
        `TECOS_ST_IDLE:
        begin
          pout_next = 1'h0;
          if (count_start && trig)
          begin
            cnt_next = reload_next;
            st_next = `TECOS_ST_RUN;
            pout_next = 1'h1;
          end
        end
        `TECOS_ST_RUN:
        begin
          // [R24] active during down-count
          pout_next = 1'h1;
          if (!count_start)
          begin
            // [R18] stop on flag clear
            st_next = `TECOS_ST_IDLE;
            pout_next = 1'h0;
          end
          else if (trig)
            // [R19] retrigger reloads
            cnt_next = reload_next;
          else if (tick)
          begin
            // [R17] count down n source cycles
            cnt_next = cnt_reg - 16'h0001;
            if (cnt_reg == 16'h0001 || cnt_reg == `TECOS_CNT_ZERO)
            begin
              // [R18] reload then stop
              cnt_next = reload_next;
              st_next = `TECOS_ST_IDLE;
              // [R21] interrupt at zero
              irq_next = 1'h1;
              pout_next = 1'h0;
            end
          end
        end
        default: st_next = `TECOS_ST_IDLE;
      endcase
    end
    // [R07] [R22] read value by mode
    rd_next = (mode_sel == `TECOS_MODE_EVENT) ? cnt_next : `TECOS_READ_JUNK;
    // [R11] [R23] [R15] output pin function
    drv_next = (out_func == `TECOS_OUT_PORT || out_func == `TECOS_OUT_PULSE)
      && src_sel != `TECOS_SRC_QUAD;
  end
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= `TECOS_CNT_RST;
      reload_reg <= `TECOS_CNT_RST;
      st_reg <= `TECOS_ST_IDLE;
      pout_reg <= 1'h0;
      os_start_d_reg <= 1'h0;
      rd_data <= 16'h0000;
      timer_out_pin <= 1'h0;
      timer_out_pin_oe_n <= 1'h1;
      irq <= 1'h0;
      running <= 1'h0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      reload_reg <= reload_next;
      st_reg <= st_next;
      pout_reg <= pout_next;
      os_start_d_reg <= oneshot_start;
      rd_data <= rd_next;
      // [R10] [R11] drive pulse or port level
      timer_out_pin <= (out_func == `TECOS_OUT_PULSE) ? pout_next : port_level;
      timer_out_pin_oe_n <= ~drv_next;
      irq <= irq_next;
      running <= st_next;
    end
  end
endmodule // tecos_timer

// ---- verification/tecos_asserts.sv ----
// assertion checker for the timer channel
`timescale 1ns/100ps
module tecos_asserts
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // controls
  input wire mode_sel,
  input wire [1:0] src_sel,
  input wire [1:0] out_func,
  input wire count_start,
  input wire wr_en,
  input wire [15:0] wr_data,
  // outputs
  input wire [15:0] rd_data,
  input wire timer_out_pin,
  input wire timer_out_pin_oe_n,
  input wire irq,
  input wire running
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ----
  // checks
  // ----
  a_write_stopped: assert property (
    !mode_sel && !count_start && wr_en ##1 !mode_sel |-> rd_data == $past(wr_data))
    else $error("no load");
  a_stop_hold: assert property (
    (!mode_sel && !count_start && !wr_en) [*2] ##1 !mode_sel |-> $stable(rd_data))
    else $error("count moved");
  a_idle_no_irq: assert property (
    (!mode_sel && !count_start) [*2] |-> !irq)
    else $error("idle irq");
  a_oneshot_read: assert property (
    mode_sel [*2] |-> rd_data == 16'h0000)
    else $error("read not masked");
  a_pulse_drive: assert property (
    (out_func == 2'h1 && src_sel != 2'h3) [*2] |-> !timer_out_pin_oe_n)
    else $error("pin not driven");
  a_dir_input: assert property (
    (out_func == 2'h2) [*2] |-> timer_out_pin_oe_n)
    else $error("pin driven");
  a_wrap_toggle: assert property (
    !mode_sel && out_func == 2'h1 && $past(out_func) == 2'h1 && irq
    |-> timer_out_pin != $past(timer_out_pin))
    else $error("no toggle");
  a_shot_pin: assert property (
    mode_sel && $past(mode_sel) && out_func == 2'h1 && $past(out_func) == 2'h1
    |-> timer_out_pin == running)
    else $error("pin off run");
  a_zero_stop: assert property (
    mode_sel && $past(mode_sel) && irq |-> !running)
    else $error("still running");
  c_evt_irq: cover property (!mode_sel && irq);
  c_shot_irq: cover property (mode_sel && irq);
  c_shot_run: cover property ($rose(running));
endmodule // tecos_asserts
bind tecos_timer tecos_asserts i_chk (.clk(clk), .sys_rst(sys_rst), .mode_sel(mode_sel),
  .src_sel(src_sel), .out_func(out_func), .count_start(count_start), .wr_en(wr_en),
  .wr_data(wr_data), .rd_data(rd_data), .timer_out_pin(timer_out_pin),
  .timer_out_pin_oe_n(timer_out_pin_oe_n), .irq(irq), .running(running));

// ---- verification/tecos_pins.sv ----
// far-side pin and neighbour pulse model
`timescale 1ns/100ps
module tecos_pins
(
  // clock
  input wire clk,
  // sources
  output logic pa,
  output logic pb,
  output logic nb,
  output logic na,
  output logic sub
);
  initial {pa, pb, nb, na, sub} = 5'h0;
  task set_a(input logic v);
    @(posedge clk) pa <= v;
    repeat (5) @(posedge clk);
  endtask
  task set_b(input logic v);
    @(posedge clk) pb <= v;
    repeat (5) @(posedge clk);
  endtask
  task tick_sub(input int k);
    repeat (k)
    begin
      @(posedge clk) sub <= 1'h1;
      repeat (4) @(posedge clk);
      sub <= 1'h0;
      repeat (4) @(posedge clk);
    end
  endtask
  task pulse(input logic b, input int k);
    repeat (k)
    begin
      @(posedge clk) {nb, na} <= b ? 2'h2 : 2'h1;
      @(posedge clk) {nb, na} <= 2'h0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // tecos_pins

// ---- verification/tb_timer_event_counter_one_shot.sv ----
// self-checking bench for the timer channel
`timescale 1ns/100ps
module tb_timer_event_counter_one_shot;
  logic clk = 1'h0;
  logic sys_rst, mode_sel, edge_fall, dir_from_pin, dir_down, free_run, trig_pin_en;
  logic trig_nb_en, count_start, oneshot_start, wr_en, port_level;
  logic [1:0] src_sel, out_func, clk_sel;
  logic [15:0] wr_data;
  logic [15:0] n_irq = 16'h0;
  wire [15:0] rd_data;
  wire pa, pb, nb, na, sub, pin, oe_n, irq, running, pin_in;
  int n_fail = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  assign pin_in = oe_n ? pb : pin;
  always @(posedge clk) if (irq === 1'h1) n_irq <= n_irq + 16'h1;
  tecos_pins i_pins (.clk(clk), .pa(pa), .pb(pb), .nb(nb), .na(na), .sub(sub));
  tecos_timer i_dut (.clk(clk), .sys_rst(sys_rst), .mode_sel(mode_sel), .src_sel(src_sel),
    .edge_fall(edge_fall), .dir_from_pin(dir_from_pin), .dir_down(dir_down),
    .free_run(free_run), .out_func(out_func), .trig_pin_en(trig_pin_en),
    .trig_nb_en(trig_nb_en), .clk_sel(clk_sel), .count_start(count_start),
    .oneshot_start(oneshot_start), .wr_en(wr_en), .wr_data(wr_data),
    .neighbour_b_timer(nb), .neighbour_a_timer(na), .timer_in_pin(pa),
    .timer_out_pin_in(pin_in), .subclock_div32_source(sub), .port_level(port_level),
    .rd_data(rd_data), .timer_out_pin(pin), .timer_out_pin_oe_n(oe_n), .irq(irq),
    .running(running));
  // ----
  // tasks
  // ----
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [15:0] v);
    @(posedge clk) {wr_en, wr_data} <= {1'h1, v};
    @(posedge clk) wr_en <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_up;
    @(posedge clk) out_func <= 2'h1;
    wr(16'hFFFE);
    chk("cnt", 16'hFFFE, rd_data);
    @(posedge clk) count_start <= 1'h1;
    i_pins.set_a(1'h1);
    chk("cnt", 16'hFFFF, rd_data);
    i_pins.set_a(1'h0);
    i_pins.set_a(1'h1);
    chk("cnt", 16'hFFFE, rd_data);
    chk("irq", 16'h1, n_irq);
    chk("pin", 16'h1, {14'h0, oe_n, pin});
  endtask
  task t_dn;
    @(posedge clk) {count_start, src_sel, out_func, dir_from_pin} <= 6'h0D;
    i_pins.set_b(1'h1);
    wr(16'h0001);
    @(posedge clk) count_start <= 1'h1;
    i_pins.pulse(1'h1, 2);
    chk("cnt", 16'h0001, rd_data);
    @(posedge clk) {free_run, src_sel} <= 3'h6;
    i_pins.pulse(1'h0, 2);
    chk("cnt", 16'hFFFF, rd_data);
    chk("irq", 16'h3, n_irq);
    wr(16'h0005);
    chk("cnt", 16'hFFFF, rd_data);
    @(posedge clk) count_start <= 1'h0;
    i_pins.pulse(1'h0, 1);
    chk("cnt", 16'hFFFF, rd_data);
  endtask
  task t_quad;
    @(posedge clk) {count_start, src_sel, dir_down} <= 4'h7;
    wr(16'h0010);
    @(posedge clk) count_start <= 1'h1;
    i_pins.set_a(1'h0);
    chk("cnt", 16'h000F, rd_data);
    i_pins.set_a(1'h1);
    chk("cnt", 16'h0010, rd_data);
    i_pins.set_b(1'h0);
    i_pins.set_a(1'h0);
    chk("cnt", 16'h0010, rd_data);
    chk("oe", 16'h1, {15'h0, oe_n});
  endtask
  task t_one;
    int k;
    int d;
    @(posedge clk) {count_start, src_sel, out_func, mode_sel} <= 6'h3;
    wr(16'h0003);
    @(posedge clk) count_start <= 1'h1;
    for (int s = 0; s < 3; s++)
    begin
      k = 0;
      d = (s == 0) ? 1 : (s == 1) ? 8 : 32;
      @(posedge clk) clk_sel <= s[1:0];
      @(posedge clk) oneshot_start <= 1'h1;
      repeat (120)
      begin
        @(posedge clk);
        #1 k += running;
      end
      @(posedge clk) oneshot_start <= 1'h0;
      chk("run", 16'h1, {15'h0, k >= 2 * d + 1 && k <= 3 * d});
    end
    chk("irq", 16'h6, n_irq);
    chk("rd", 16'h0, rd_data);
  endtask
  task t_trig;
    @(posedge clk) {clk_sel, trig_pin_en} <= 3'h1;
    i_pins.set_a(1'h1);
    repeat (4) @(posedge clk);
    chk("irq", 16'h7, n_irq);
    @(posedge clk) {trig_pin_en, trig_nb_en} <= 2'h1;
    i_pins.pulse(1'h1, 1);
    repeat (3) @(posedge clk);
    chk("irq", 16'h8, n_irq);
    @(posedge clk) {clk_sel, trig_nb_en} <= 3'h6;
    @(posedge clk) oneshot_start <= 1'h1;
    repeat (4) @(posedge clk);
    chk("run", 16'h1, {15'h0, running});
    i_pins.tick_sub(4);
    chk("irq", 16'h9, n_irq);
    @(posedge clk) {mode_sel, edge_fall, out_func, port_level, free_run, oneshot_start} <= 7'h24;
    i_pins.set_a(1'h0);
    chk("cnt", 16'h0002, rd_data);
    chk("pin", 16'h1, {14'h0, oe_n, pin});
    i_pins.set_a(1'h1);
    chk("cnt", 16'h0002, rd_data);
  endtask
  initial
  begin
    {sys_rst, mode_sel, edge_fall, dir_from_pin, dir_down, free_run, trig_pin_en} = 7'h40;
    {trig_nb_en, count_start, oneshot_start, wr_en, port_level} = 5'h0;
    {src_sel, out_func, clk_sel, wr_data} = 22'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    t_up;
    t_dn;
    t_quad;
    t_one;
    t_trig;
    complete_run;
  end
  initial
  begin
    repeat (4000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule // tb_timer_event_counter_one_shot
